// ### include/smc_pkg.sv
package smc_pkg;

  // ---------------------------------------------------------------
  // Register byte offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] SMC_OFS_CTRL = 8'h00;
  localparam logic [7:0] SMC_OFS_EN = 8'h04;
  localparam logic [7:0] SMC_OFS_STAT = 8'h08;
  localparam logic [7:0] SMC_OFS_TXD = 8'h0c;
  localparam logic [7:0] SMC_OFS_RXD = 8'h10;
  localparam logic [7:0] SMC_OFS_DIV = 8'h14;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int SMC_CTRL_LOW_BIT_FIRST = 0;
  localparam int SMC_CTRL_DIR = 1;
  localparam int SMC_CTRL_SEL_LO = 2;
  localparam int SMC_CTRL_SEL_HI = 3;
  localparam int SMC_CTRL_SRST = 4;
  localparam int SMC_CTRL_AUTO = 5;
  localparam int SMC_CTRL_CE = 6;
  localparam int SMC_EN_BIT = 0;
  localparam int SMC_STAT_TX_BUFFER_EMPTY = 0;
  localparam int SMC_STAT_RX_BUFFER_FULL = 1;
  localparam int SMC_STAT_ACT = 2;

  // ---------------------------------------------------------------
  // Encodings and reset values
  // ---------------------------------------------------------------
  localparam logic [1:0] SMC_SEL_FULL = 2'h0;
  localparam logic [1:0] SMC_SEL_HALF = 2'h1;
  localparam logic [7:0] SMC_DIV_RST = 8'h04;
  localparam logic [7:0] SMC_BYTE_RST = 8'h00;
  localparam logic [2:0] SMC_LAST_SINGLE = 3'h7;
  localparam logic [2:0] SMC_LAST_DUAL = 3'h3;

  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef struct packed {
    logic ce;
    logic auto_read;
    logic [1:0] input_line_choice;
    logic out_pin_direction;
    logic low_bit_first;
  } smc_ctrl_t;

  localparam smc_ctrl_t SMC_CTRL_RST = '{ce: 1'b0, auto_read: 1'b0, input_line_choice: SMC_SEL_FULL,
                                         out_pin_direction: 1'b1, low_bit_first: 1'b0};

  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } smc_bus_req_t;

  typedef enum logic [1:0] {SMC_IDLE, SMC_LOW, SMC_HIGH} smc_state_t;

endpackage

// ### rtl/smc_spi_master.sv
// Operation
// [RULE1] Chip-select bit one drives select low
// [RULE2] Auto-read: receive read clears both flags
// [RULE3] No auto-read: receive read clears full only
// [RULE4] Soft reset bit self-clears; zero ignored
// [RULE5] Soft reset returns whole interface to reset
// [RULE6] Input choice picks lines when pin inputs
// [RULE7] Upper choice bit: both input lines
// [RULE8] Choice 01: secondary input line only
// [RULE9] Choice 00: primary line only, reset
// [RULE10] Half/dual: output pin bidirectional by direction
// [RULE11] Direction changes only between bytes
// [RULE12] Direction one output, zero input; resets one
// [RULE13] Bit-order one shifts least bit first
// [RULE14] Receive full set on fill, cleared on read
// [RULE15] Receive full offered as interrupt source
// [RULE16] Transmit empty cleared by transmit write
// [RULE17] Transmit empty resets one, interrupt source
// [RULE18] Disabled: clocks gated, pins held inactive; the code still drives chip select from the select bit
// [RULE19] Write while empty starts transfer immediately
// [RULE20] Byte written mid-shift waits, then loads
// [RULE21] Software never writes transmit while not empty
// [RULE22] Active flag shows byte in progress
//
// Added by the designer: the plain strobed port.
module smc_spi_master
  import smc_pkg::*;
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_resetn,
  // Register port
  input wire smc_bus_req_t i_bus,
  output logic [31:0] o_rdata,
  // Interrupt sources
  output logic o_rx_irq,
  output logic o_tx_irq,
  // Serial pins
  output logic o_spi_cs_n,
  output logic o_spi_clk,
  output logic o_serial_out_line,
  output logic o_serial_out_line_oe,
  input wire logic i_serial_out_line,
  input wire logic i_serial_in_primary,
  input wire logic i_serial_in_secondary
);

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  function automatic logic [7:0] rx_shift(input logic [7:0] cur, input logic pri, input logic sec,
                                          input logic two, input logic lsb);
    logic [7:0] r;
    r = cur;
    if (two && lsb) begin
      r = {sec, pri, cur[7:2]};
    end else if (two) begin
      r = {cur[5:0], pri, sec};
    end else if (lsb) begin
      r = {pri, cur[7:1]};
    end else begin
      r = {cur[6:0], pri};
    end
    return r;
  endfunction

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  smc_ctrl_t ctrl_ff;
  logic soft_rst_ff;
  logic enable_ff;
  logic [7:0] div_ff;
  logic [7:0] div_cnt_ff;
  logic [7:0] tx_data_ff;
  logic pend_ff;
  logic tx_buffer_empty_ff;
  logic rx_buffer_full_ff;
  logic [7:0] rx_hold_ff;
  logic [7:0] tx_sh_ff;
  logic [7:0] rx_sh_ff;
  logic [2:0] bit_cnt_ff;
  logic dir_ff;
  logic lsb_ff;
  logic two_ff;
  logic bidir_ff;
  logic sclk_ff;
  smc_state_t state_ff;
  logic [31:0] rdata_ff;
  logic cs_n_ff;
  logic sout_ff;
  logic oe_ff;
  logic [2:0] sync1_ff;
  logic [2:0] sync2_ff;

  // ---------------------------------------------------------------
  // Decode
  // ---------------------------------------------------------------
  logic wr_ctrl;
  logic wr_en;
  logic wr_div;
  logic wr_tx;
  logic rd_rx;
  logic tick;
  logic last_bit;
  logic byte_done;
  logic load_direct;
  logic load_pend;
  logic load;
  logic [7:0] load_data;
  logic in_pri;
  logic in_sec;
  logic sel_two;

  assign wr_ctrl = i_bus.wr && (i_bus.addr == SMC_OFS_CTRL);
  assign wr_en = i_bus.wr && (i_bus.addr == SMC_OFS_EN);
  assign wr_div = i_bus.wr && (i_bus.addr == SMC_OFS_DIV);
  assign wr_tx = i_bus.wr && (i_bus.addr == SMC_OFS_TXD);
  assign rd_rx = i_bus.rd && (i_bus.addr == SMC_OFS_RXD);

  // Clock gating: the divider only runs while a byte is moving
  assign tick = enable_ff && (state_ff != SMC_IDLE) && (div_cnt_ff == div_ff); // [RULE18]
  assign last_bit = bit_cnt_ff == (two_ff ? SMC_LAST_DUAL : SMC_LAST_SINGLE);
  assign byte_done = (state_ff == SMC_HIGH) && tick && last_bit;

  assign load_direct = wr_tx && enable_ff && (state_ff == SMC_IDLE) && !pend_ff; // [RULE19]
  assign load_pend = pend_ff && enable_ff && ((state_ff == SMC_IDLE) || byte_done); // [RULE20]
  assign load = load_direct || load_pend;
  assign load_data = load_direct ? i_bus.wdata[7:0] : tx_data_ff;

  // Dual capture only while the output pin is turned around
  assign sel_two = ctrl_ff.input_line_choice[1] && !ctrl_ff.out_pin_direction; // [RULE7]

  // Input line choice: dual capture latched per byte through two_ff, single-line pick read live from ctrl_ff
  always_comb begin
    in_pri = sync2_ff[0];
    in_sec = sync2_ff[1];
    if (!two_ff && (ctrl_ff.input_line_choice == SMC_SEL_HALF)) begin
      in_pri = sync2_ff[1]; // [RULE8] [RULE6]
    end else if (!two_ff) begin
      in_pri = sync2_ff[0]; // [RULE9] [RULE6]
    end
  end

  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      sync1_ff <= 3'h0;
      sync2_ff <= 3'h0;
    end else begin
      sync1_ff <= {i_serial_out_line, i_serial_in_secondary, i_serial_in_primary};
      sync2_ff <= sync1_ff;
    end
  end

  // ---------------------------------------------------------------
  // Control, enable and divider registers
  // ---------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      soft_rst_ff <= 1'b0;
    end else begin
      // Single-cycle pulse; a zero write leaves it low
      soft_rst_ff <= wr_ctrl && i_bus.wdata[SMC_CTRL_SRST]; // [RULE4]
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      ctrl_ff <= SMC_CTRL_RST;
      enable_ff <= 1'b0;
      div_ff <= SMC_DIV_RST;
    end else if (soft_rst_ff) begin
      ctrl_ff <= SMC_CTRL_RST; // [RULE5] [RULE12]
      enable_ff <= 1'b0;
      div_ff <= SMC_DIV_RST;
    end else begin
      if (wr_ctrl) begin
        ctrl_ff.ce <= i_bus.wdata[SMC_CTRL_CE];
        ctrl_ff.auto_read <= i_bus.wdata[SMC_CTRL_AUTO];
        ctrl_ff.input_line_choice <= i_bus.wdata[SMC_CTRL_SEL_HI:SMC_CTRL_SEL_LO];
        ctrl_ff.out_pin_direction <= i_bus.wdata[SMC_CTRL_DIR];
        ctrl_ff.low_bit_first <= i_bus.wdata[SMC_CTRL_LOW_BIT_FIRST];
      end
      if (wr_en) begin
        enable_ff <= i_bus.wdata[SMC_EN_BIT];
      end
      if (wr_div) begin
        div_ff <= i_bus.wdata[7:0];
      end
    end
  end

  // ---------------------------------------------------------------
  // Transmit holding register and flags
  // ---------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      tx_data_ff <= SMC_BYTE_RST;
      pend_ff <= 1'b0;
    end else if (soft_rst_ff) begin
      tx_data_ff <= SMC_BYTE_RST;
      pend_ff <= 1'b0;
    end else begin
      if (wr_tx) begin
        tx_data_ff <= i_bus.wdata[7:0];
      end
      // A write landing on a pending byte overwrites it
      if (wr_tx && !load_direct) begin
        pend_ff <= 1'b1; // [RULE20]
      end else if (load_pend) begin
        pend_ff <= 1'b0;
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      tx_buffer_empty_ff <= 1'b1; // [RULE17]
    end else if (soft_rst_ff) begin
      tx_buffer_empty_ff <= 1'b1;
    end else if (load) begin
      // Any load frees the holding register, even one that follows an auto-read clear
      tx_buffer_empty_ff <= 1'b1; // [RULE19] [RULE20]
    end else if (wr_tx && !load_direct) begin
      tx_buffer_empty_ff <= 1'b0; // [RULE16]
    end else if (rd_rx && ctrl_ff.auto_read) begin
      tx_buffer_empty_ff <= 1'b0; // [RULE2]
    end
  end

  // Set beats clear so a byte finishing on the read is not lost
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      rx_buffer_full_ff <= 1'b0;
      rx_hold_ff <= SMC_BYTE_RST;
    end else if (soft_rst_ff) begin
      rx_buffer_full_ff <= 1'b0;
      rx_hold_ff <= SMC_BYTE_RST;
    end else if (byte_done) begin
      rx_buffer_full_ff <= 1'b1; // [RULE14]
      rx_hold_ff <= rx_sh_ff;
    end else if (rd_rx) begin
      rx_buffer_full_ff <= 1'b0; // [RULE14] [RULE3]
    end
  end

  // ---------------------------------------------------------------
  // Shift engine
  // ---------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      div_cnt_ff <= SMC_BYTE_RST;
    end else if (soft_rst_ff || tick || (state_ff == SMC_IDLE) || !enable_ff) begin
      div_cnt_ff <= SMC_BYTE_RST;
    end else begin
      div_cnt_ff <= div_cnt_ff + 8'h01;
    end
  end

  // Per-byte settings are frozen at load so a mid-byte write cannot turn the pin
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      dir_ff <= 1'b1;
      lsb_ff <= 1'b0;
      two_ff <= 1'b0;
      bidir_ff <= 1'b0;
    end else if (soft_rst_ff) begin
      dir_ff <= 1'b1;
      lsb_ff <= 1'b0;
      two_ff <= 1'b0;
      bidir_ff <= 1'b0;
    end else if (load) begin
      dir_ff <= ctrl_ff.out_pin_direction; // [RULE11]
      lsb_ff <= ctrl_ff.low_bit_first;
      two_ff <= sel_two;
      bidir_ff <= ctrl_ff.input_line_choice != SMC_SEL_FULL; // [RULE10]
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      state_ff <= SMC_IDLE;
      sclk_ff <= 1'b0;
      bit_cnt_ff <= 3'h0;
      tx_sh_ff <= SMC_BYTE_RST;
      rx_sh_ff <= SMC_BYTE_RST;
    end else if (soft_rst_ff || !enable_ff) begin
      // Disabling mid-byte abandons it and parks the clock low
      state_ff <= SMC_IDLE; // [RULE5] [RULE18]
      sclk_ff <= 1'b0;
      bit_cnt_ff <= 3'h0;
      if (soft_rst_ff) begin
        tx_sh_ff <= SMC_BYTE_RST;
        rx_sh_ff <= SMC_BYTE_RST;
      end
    end else if (load) begin
      state_ff <= SMC_LOW; // [RULE19]
      sclk_ff <= 1'b0;
      bit_cnt_ff <= 3'h0;
      tx_sh_ff <= load_data;
    end else begin
      case (state_ff)
        SMC_IDLE: begin
          sclk_ff <= 1'b0;
        end
        SMC_LOW: begin
          if (tick) begin
            state_ff <= SMC_HIGH;
            sclk_ff <= 1'b1;
            rx_sh_ff <= rx_shift(rx_sh_ff, in_pri, in_sec, two_ff, lsb_ff); // [RULE13]
          end
        end
        SMC_HIGH: begin
          if (tick) begin
            sclk_ff <= 1'b0;
            if (last_bit) begin
              state_ff <= SMC_IDLE;
            end else begin
              state_ff <= SMC_LOW;
              bit_cnt_ff <= bit_cnt_ff + 3'h1;
              tx_sh_ff <= lsb_ff ? {1'b0, tx_sh_ff[7:1]} : {tx_sh_ff[6:0], 1'b0}; // [RULE13]
            end
          end
        end
        default: begin
          state_ff <= SMC_IDLE;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Pin outputs
  // ---------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      cs_n_ff <= 1'b1;
      sout_ff <= 1'b0;
      oe_ff <= 1'b1;
    end else begin
      cs_n_ff <= soft_rst_ff ? 1'b1 : !ctrl_ff.ce; // [RULE1]
      sout_ff <= enable_ff && !soft_rst_ff && (state_ff != SMC_IDLE) &&
                 (lsb_ff ? tx_sh_ff[0] : tx_sh_ff[7]); // [RULE18]
      oe_ff <= soft_rst_ff || !bidir_ff || dir_ff; // [RULE10] [RULE12]
    end
  end

  // ---------------------------------------------------------------
  // Read port
  // ---------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      rdata_ff <= 32'h0;
    end else begin
      rdata_ff <= 32'h0;
      if (i_bus.rd) begin
        case (i_bus.addr)
          SMC_OFS_CTRL: begin
            rdata_ff[SMC_CTRL_CE] <= ctrl_ff.ce;
            rdata_ff[SMC_CTRL_AUTO] <= ctrl_ff.auto_read;
            rdata_ff[SMC_CTRL_SRST] <= soft_rst_ff;
            rdata_ff[SMC_CTRL_SEL_HI:SMC_CTRL_SEL_LO] <= ctrl_ff.input_line_choice;
            rdata_ff[SMC_CTRL_DIR] <= ctrl_ff.out_pin_direction;
            rdata_ff[SMC_CTRL_LOW_BIT_FIRST] <= ctrl_ff.low_bit_first;
          end
          SMC_OFS_EN: begin
            rdata_ff[SMC_EN_BIT] <= enable_ff;
          end
          SMC_OFS_STAT: begin
            rdata_ff[SMC_STAT_ACT] <= state_ff != SMC_IDLE; // [RULE22]
            rdata_ff[SMC_STAT_RX_BUFFER_FULL] <= rx_buffer_full_ff;
            rdata_ff[SMC_STAT_TX_BUFFER_EMPTY] <= tx_buffer_empty_ff;
          end
          SMC_OFS_TXD: begin
            rdata_ff[7:0] <= tx_data_ff;
          end
          SMC_OFS_RXD: begin
            rdata_ff[7:0] <= rx_hold_ff;
          end
          SMC_OFS_DIV: begin
            rdata_ff[7:0] <= div_ff;
          end
          default: begin
            rdata_ff <= 32'h0;
          end
        endcase
      end
    end
  end

  assign o_rdata = rdata_ff;
  assign o_rx_irq = rx_buffer_full_ff; // [RULE15]
  assign o_tx_irq = tx_buffer_empty_ff; // [RULE17]
  assign o_spi_cs_n = cs_n_ff;
  assign o_spi_clk = sclk_ff;
  assign o_serial_out_line = sout_ff;
  assign o_serial_out_line_oe = oe_ff;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_resetn || soft_rst_ff);

  a_cs_follows_ce: assert property (!soft_rst_ff |=> o_spi_cs_n == !$past(ctrl_ff.ce)) // [RULE1]
    else $error("chip select does not follow enable bit");
  a_auto_read_clr: assert property (rd_rx && ctrl_ff.auto_read && !byte_done && !load_pend
                                    |=> !tx_buffer_empty_ff && !rx_buffer_full_ff) // [RULE2]
    else $error("auto read did not clear both flags");
  a_plain_read_keep: assert property (rd_rx && !ctrl_ff.auto_read && !byte_done && !wr_tx && !load_pend
                                      |=> !rx_buffer_full_ff && (tx_buffer_empty_ff == $past(tx_buffer_empty_ff))) // [RULE3]
    else $error("plain read disturbed transmit empty");
  a_srst_self_clr: assert property (@(posedge i_clk) disable iff (!i_resetn)
                                    soft_rst_ff |=> !soft_rst_ff) // [RULE4]
    else $error("soft reset bit did not clear");
  a_srst_restores: assert property (@(posedge i_clk) disable iff (!i_resetn)
                                    soft_rst_ff |=> tx_buffer_empty_ff && !rx_buffer_full_ff && (state_ff == SMC_IDLE)
                                    && (ctrl_ff == SMC_CTRL_RST) && !enable_ff) // [RULE5]
    else $error("soft reset left state behind");
  a_dual_capture: assert property (load && ctrl_ff.input_line_choice[1] && !ctrl_ff.out_pin_direction
                                   |=> two_ff) // [RULE7]
    else $error("dual choice did not enable both lines");
  a_dir_midbyte: assert property ((state_ff != SMC_IDLE) && !load |=> $stable(dir_ff)) // [RULE11]
    else $error("direction changed during a byte");
  a_oe_by_dir: assert property (!soft_rst_ff |=> o_serial_out_line_oe == (!$past(bidir_ff) || $past(dir_ff))) // [RULE12]
    else $error("output enable does not match direction");
  a_rx_buffer_full_on_done: assert property (byte_done |=> rx_buffer_full_ff ##0 (rx_hold_ff == $past(rx_sh_ff))) // [RULE14]
    else $error("receive full not set at byte end");
  a_tx_buffer_empty_on_write: assert property (wr_tx && !load_direct && !load_pend |=> !tx_buffer_empty_ff) // [RULE16]
    else $error("transmit write did not clear empty");
  a_pend_reload: assert property (byte_done && pend_ff |=> tx_buffer_empty_ff && (state_ff == SMC_LOW)
                                  && (tx_sh_ff == $past(tx_data_ff))) // [RULE20]
    else $error("pending byte not loaded at byte end");
  a_disabled_quiet: assert property (!enable_ff |=> !o_spi_clk ##1 !o_serial_out_line) // [RULE18]
    else $error("pins active while disabled");

  c_full_byte: cover property (byte_done && !two_ff && !bidir_ff);
  c_dual_byte: cover property (byte_done && two_ff);
  c_pend_load: cover property (byte_done && pend_ff);
  c_auto_read: cover property (rd_rx && ctrl_ff.auto_read && rx_buffer_full_ff);

endmodule // smc_spi_master

// ### verif/smc_spi_master_tb_top.sv
module smc_spi_master_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import smc_pkg::*;

  logic i_clk;
  logic i_resetn;
  smc_bus_req_t bus;
  logic [31:0] rdata;
  logic rx_irq;
  logic tx_irq;
  logic cs_n;
  logic sclk;
  logic sout;
  logic soe;
  logic prim;
  logic sec;
  logic [7:0] mosi;
  logic [31:0] v;
  wire pin;
  int mismatches;
  int compares;

  // Undriven pin shows the inverse so a stale value cannot pass
  assign pin = soe ? sout : ~sout;

  smc_spi_master smc_spi_master_i (
    .i_clk(i_clk), .i_resetn(i_resetn), .i_bus(bus), .o_rdata(rdata),
    .o_rx_irq(rx_irq), .o_tx_irq(tx_irq), .o_spi_cs_n(cs_n), .o_spi_clk(sclk),
    .o_serial_out_line(sout), .o_serial_out_line_oe(soe), .i_serial_out_line(pin),
    .i_serial_in_primary(prim), .i_serial_in_secondary(sec)
  );

  smc_spi_slave_model smc_spi_slave_model_i (
    .i_cs_n(cs_n), .i_sclk(sclk), .i_pin(pin), .o_prim(prim), .o_sec(sec), .o_mosi(mosi)
  );

  initial begin
    i_clk = 1'h0;
    forever #25 i_clk = ~i_clk;
  end

  // ---------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------
  task automatic stop_test();
    if (mismatches == 0 && compares > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string nm);
    compares++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk);
    bus <= '{addr: a, wdata: d, wr: 1'h1, rd: 1'h0};
    @(posedge i_clk);
    bus <= '{addr: a, wdata: 32'h0, wr: 1'h0, rd: 1'h0};
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] exp, input string nm);
    @(posedge i_clk);
    bus <= '{addr: a, wdata: 32'h0, wr: 1'h0, rd: 1'h1};
    @(posedge i_clk);
    bus <= '{addr: a, wdata: 32'h0, wr: 1'h0, rd: 1'h0};
    #1 v = rdata;
    chk(v, exp, nm);
  endtask

  // Optionally checks the pin direction stays steady while a byte runs
  task automatic wait_rx(input logic eo_on, input logic eo);
    int n;
    n = 0;
    while (rx_irq !== 1'h1) begin
      if (eo_on) chk({31'h0, soe}, {31'h0, eo}, "oe hold");
      @(posedge i_clk);
      #1 n++;
      if (n > 400) begin
        mismatches++;
        stop_test();
      end
    end
  endtask

  task automatic xfer(input logic [7:0] c, input logic [7:0] tx, input logic [7:0] erx,
                      input logic [7:0] emo, input logic mo_on);
    wr(SMC_OFS_CTRL, {24'h0, c & 8'hbf});
    wr(SMC_OFS_CTRL, {24'h0, c});
    wr(SMC_OFS_TXD, {24'h0, tx});
    chk({31'h0, cs_n}, 32'h0, "cs low");
    rchk(SMC_OFS_STAT, 32'h5, "stat busy");
    chk({31'h0, soe}, {31'h0, (c[3:2] == 2'h0) | c[1]}, "oe");
    wait_rx(1'h0, 1'h0);
    rchk(SMC_OFS_STAT, 32'h3, "stat done");
    if (mo_on) chk({24'h0, mosi}, {24'h0, emo}, "mosi");
    rchk(SMC_OFS_RXD, {24'h0, erx}, "rx data");
    chk({31'h0, rx_irq}, 32'h0, "rx irq");
    rchk(SMC_OFS_STAT, {31'h0, ~c[5]}, "stat after read");
    chk({31'h0, tx_irq}, {31'h0, ~c[5]}, "tx irq");
  endtask

  // ---------------------------------------------------------------
  // Sequence
  // ---------------------------------------------------------------
  initial begin
    bus = '0;
    i_resetn = 1'h0;
    mismatches = 0;
    compares = 0;
    repeat (8) @(posedge i_clk);
    i_resetn <= 1'h1;
    #1 chk({26'h0, cs_n, tx_irq, rx_irq, sclk, sout, soe}, 32'h31, "pins reset");
    wr(8'h18, 32'hff);
    rchk(SMC_OFS_CTRL, 32'h2, "ctrl reset");
    rchk(SMC_OFS_STAT, 32'h1, "stat reset");
    rchk(SMC_OFS_DIV, 32'h4, "div reset");
    rchk(8'h18, 32'h0, "unmapped");
    // Disabled block: byte only waits, clock and data pins stay quiet
    wr(SMC_OFS_CTRL, 32'h40);
    rchk(SMC_OFS_CTRL, 32'h40, "ctrl zero reset bit");
    chk({31'h0, cs_n}, 32'h0, "cs on");
    wr(SMC_OFS_TXD, 32'h55);
    rchk(SMC_OFS_STAT, 32'h0, "stat pending");
    repeat (30) begin
      @(posedge i_clk);
      #1 chk({30'h0, sclk, sout}, 32'h0, "idle pins");
    end
    wr(SMC_OFS_CTRL, 32'h10);
    @(posedge i_clk);
    rchk(SMC_OFS_CTRL, 32'h2, "ctrl soft reset");
    rchk(SMC_OFS_STAT, 32'h1, "stat soft reset");
    rchk(SMC_OFS_TXD, 32'h0, "tx soft reset");
    chk({31'h0, cs_n}, 32'h1, "cs soft reset");
    // Divider 3 gives the 400 ns link period
    wr(SMC_OFS_DIV, 32'h3);
    wr(SMC_OFS_EN, 32'h1);
    xfer(8'h42, 8'hc6, 8'hb4, 8'hc6, 1'h1);
    xfer(8'h63, 8'hc6, 8'h2d, 8'h63, 1'h1);
    xfer(8'h44, 8'hc6, 8'h63, 8'h00, 1'h0);
    xfer(8'h48, 8'hc6, 8'h9e, 8'h00, 1'h0);
    xfer(8'h4c, 8'hc6, 8'h9e, 8'h00, 1'h0);
    // Back to back with a direction change in mid byte
    wr(SMC_OFS_CTRL, 32'h06);
    wr(SMC_OFS_CTRL, 32'h46);
    wr(SMC_OFS_TXD, 32'h11);
    wr(SMC_OFS_TXD, 32'h22); // Written at once while the first byte shifts; this write clears empty until the pending byte loads
    rchk(SMC_OFS_STAT, 32'h4, "stat waiting byte");
    wr(SMC_OFS_CTRL, 32'h44);
    wait_rx(1'h1, 1'h1);
    chk({24'h0, mosi}, 32'h11, "mosi first");
    rchk(SMC_OFS_STAT, 32'h7, "stat reload");
    rchk(SMC_OFS_RXD, 32'h63, "rx first");
    chk({31'h0, soe}, 32'h0, "oe next byte");
    wait_rx(1'h1, 1'h0);
    rchk(SMC_OFS_RXD, 32'h63, "rx second");
    rchk(SMC_OFS_STAT, 32'h1, "stat end");
    stop_test();
  end
endmodule // smc_spi_master_tb_top

// ### verif/smc_spi_slave_model.sv
// ---------------------------------------------------------------
// Mode 0 slave: drives both input lines, captures the out pin
// ---------------------------------------------------------------
module smc_spi_slave_model #(
  parameter logic [7:0] P_PAT = 8'hb4,
  parameter logic [7:0] S_PAT = 8'h63
) (
  // Link
  input wire logic i_cs_n,
  input wire logic i_sclk,
  input wire logic i_pin,
  // Lines toward the master
  output logic o_prim,
  output logic o_sec,
  output logic [7:0] o_mosi
);
  timeunit 1ns;
  timeprecision 100ps;

  logic [7:0] sp;
  logic [7:0] ss;

  // Patterns rotate per clock and reload whenever select goes high
  always @(negedge i_sclk or posedge i_cs_n) begin
    if (i_cs_n) begin
      sp = P_PAT;
      ss = S_PAT;
    end else begin
      sp = {sp[6:0], sp[7]};
      ss = {ss[6:0], ss[7]};
    end
  end

  always @(posedge i_sclk) begin
    if (!i_cs_n) begin
      o_mosi = {o_mosi[6:0], i_pin};
    end
  end

  // Not selected: lines show the inverse, never a stale copy
  assign o_prim = i_cs_n ? ~sp[7] : sp[7];
  assign o_sec = i_cs_n ? ~ss[7] : ss[7];
endmodule // smc_spi_slave_model
